//--- rtl/bcs_boot_config_selector.sv
// Boot config selector: bank alias choice and configuration load at start-up
//
// Summary of operation
// - Equal or higher first sequence maps first low
// - Strictly higher second sequence swaps the mapping
// - Sequence valid only when complement matches exactly
// - Failed complement check uses the alternate word
// - Load configuration from lower-aliased bank
// - Each sequence and configuration word has alternate
// - Primary uncorrectable error sets flag, uses alternate
// - Both copies bad sets fail flag, defaults
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "bcs_map.svh"
module bcs_boot_config_selector (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Boot flash read port
    output logic flashReq,
    output logic flashBank,
    output logic [4:0] flashAddr,
    input wire logic flashAck,
    input wire logic [31:0] flashData,
    input wire logic flashEccUncorr,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration outputs
    output logic [31:0] deviceSignatureWord,
    output logic [31:0] codeProtectWord,
    output logic [95:0] deviceConfigWords,
    output logic lowerIsSecond,
    output logic bootCfgErrorFlag,
    output logic bootCfgFailFlag,
    output logic loadDone,
    output logic irq
);
    import bcs_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Sequence is valid only if complement is the exact inverse
    function automatic logic seqValid(input logic [31:0] w);
        return w[31:16] == ~w[15:0];
    endfunction

    // Address of a word, primary or alternate copy
    function automatic logic [4:0] wordAddr(input logic [2:0] i, input logic a);
        return {1'b0, i} + (a ? {1'b0, `BCS_ALT_OFS} : 5'h00);
    endfunction

    // Whole state in one struct; n is the value it takes at the next edge
    bcs_regs_t r, n;
    logic rdFire;
    logic wrFire;
    logic wrTake;
    logic [2:0] evt;
    logic [2:0] wrMask;

    // Mask field of the write data
    assign wrMask = pwdata[2:0];

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        n = r;
        evt = 3'b000;
        rdFire = psel && penable && !pwrite && !r.pready;
        wrFire = psel && penable && pwrite && !r.pready;
        // The write itself waits for the edge at which ready is seen high
        wrTake = psel && penable && pwrite && r.pready;
        unique case (r.state)
            BCS_IDLE: begin
                // Sequence words always fetched before any config word
                n.state = BCS_SEQ1;
                n.alt = 1'b0;
                n.flashReq = 1'b1;
                n.flashBank = 1'b0;
                n.flashAddr = wordAddr(`BCS_IDX_SEQ, 1'b0);
            end
            BCS_SEQ1, BCS_SEQ2: begin
                if (flashAck && r.flashReq) begin
                    n.flashReq = 1'b0;
                    if ((flashEccUncorr || !seqValid(flashData)) && !r.alt) begin
                        // Bad primary: retry with the alternate copy
                        n.alt = 1'b1;
                        if (flashEccUncorr) begin
                            n.cfgErr = 1'b1;
                        end
                        n.flashReq = 1'b1;
                        n.flashAddr = wordAddr(`BCS_IDX_SEQ, 1'b1);
                    end else begin
                        // Unusable alternate counts as sequence zero
                        if (r.state == BCS_SEQ1) begin
                            n.seq1 = (flashEccUncorr || !seqValid(flashData)) ?
                                16'h0000 : flashData[15:0];
                            n.state = BCS_SEQ2;
                            n.flashBank = 1'b1;
                        end else begin
                            n.seq2 = (flashEccUncorr || !seqValid(flashData)) ?
                                16'h0000 : flashData[15:0];
                            // Ties keep first bank low second higher swaps
                            n.lowerIsSecond = n.seq2 > r.seq1;
                            n.flashBank = n.seq2 > r.seq1;
                            n.state = BCS_CFG;
                        end
                        if (flashEccUncorr && r.alt) begin
                            n.cfgFail = 1'b1;
                        end
                        n.alt = 1'b0;
                        n.idx = (r.state == BCS_SEQ1) ? `BCS_IDX_SEQ : `BCS_IDX_SIG;
                        n.flashReq = 1'b1;
                        n.flashAddr = wordAddr(n.idx, 1'b0);
                    end
                end
            end
            BCS_CFG: begin
                if (flashAck && r.flashReq) begin
                    n.flashReq = 1'b0;
                    if (flashEccUncorr && !r.alt) begin
                        n.cfgErr = 1'b1;
                        n.alt = 1'b1;
                        n.flashReq = 1'b1;
                        n.flashAddr = wordAddr(r.idx, 1'b1);
                    end else begin
                        if (flashEccUncorr) begin
                            // Both copies bad: default value
                            n.cfgFail = 1'b1;
                            n.cfg[r.idx - 3'h1] = `BCS_DEF_WORD;
                        end else begin
                            n.cfg[r.idx - 3'h1] = flashData;
                        end
                        n.alt = 1'b0;
                        // Last word closes the load and posts the events
                        if (r.idx == `BCS_NUM_WORDS) begin
                            n.state = BCS_DONE;
                            evt[`BCS_ST_DONE] = 1'b1;
                            evt[`BCS_ST_ERR] = n.cfgErr;
                            evt[`BCS_ST_FAIL] = n.cfgFail;
                        end else begin
                            n.idx = r.idx + 3'h1;
                            n.flashReq = 1'b1;
                            n.flashAddr = wordAddr(n.idx, 1'b0);
                        end
                    end
                end
            end
            BCS_DONE: begin
                // Mapping and configuration frozen until reset
                n.state = BCS_DONE;
            end
        endcase
        // Any failure forces the whole default set
        if (evt[`BCS_ST_FAIL]) begin
            for (int k = 0; k < 6; k++) begin
                n.cfg[k] = `BCS_DEF_WORD;
            end
        end

        // ----------------------------------------
        // Register bus
        // ----------------------------------------
        // One wait state: ready follows the first access edge
        n.pready = rdFire || wrFire;
        n.pslverr = 1'b0;
        n.prdata = 32'h0000_0000;
        if (rdFire) begin
            case (paddr)
                `BCS_OFF_STATUS: begin
                    n.prdata = {29'h0, r.status};
                    n.status = 3'b000; // Cleared by read
                end
                `BCS_OFF_MASK: n.prdata = {29'h0, r.mask};
                `BCS_OFF_RESET_CONTROL_REGISTER: begin
                    n.prdata[`BCS_RESET_CONTROL_REGISTER_ERR_BIT] = r.cfgErr;
                    n.prdata[`BCS_RESET_CONTROL_REGISTER_FAIL_BIT] = r.cfgFail;
                end
                `BCS_OFF_SIG: n.prdata = r.cfg[0];
                `BCS_OFF_CP: n.prdata = r.cfg[1];
                `BCS_OFF_CFG0: n.prdata = r.cfg[2];
                `BCS_OFF_CFG1: n.prdata = r.cfg[3];
                `BCS_OFF_CFG2: n.prdata = r.cfg[4];
                `BCS_OFF_MAP: n.prdata = {30'h0, r.state == BCS_DONE, r.lowerIsSecond};
                default: n.pslverr = 1'b1;
            endcase
        end
        // A write to anything but mask or status is refused with an error
        if (wrFire && paddr != `BCS_OFF_MASK && paddr != `BCS_OFF_STATUS) begin
            n.pslverr = 1'b1;
        end
        // Mask changes only at the edge that ends the transfer
        if (wrTake && paddr == `BCS_OFF_MASK) begin
            n.mask = wrMask;
        end
        // Set wins over the read clear
        n.status = n.status | evt;
        n.irq = |(n.status & n.mask);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from flops
    assign flashReq = r.flashReq;
    assign flashBank = r.flashBank;
    assign flashAddr = r.flashAddr;
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign deviceSignatureWord = r.cfg[0];
    assign codeProtectWord = r.cfg[1];
    assign deviceConfigWords = {r.cfg[4], r.cfg[3], r.cfg[2]};
    assign lowerIsSecond = r.lowerIsSecond;
    assign bootCfgErrorFlag = r.cfgErr;
    assign bootCfgFailFlag = r.cfgFail;
    assign loadDone = r.state[2]; // Only the done code has its top bit set
    assign irq = r.irq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence sSeq2Ok;
        r.state == BCS_SEQ2 && flashAck && r.flashReq && !flashEccUncorr
            && seqValid(flashData);
    endsequence

    AST_TIE_FIRST_LOW: assert property (@(posedge clock) disable iff (rst)
        sSeq2Ok and (flashData[15:0] <= r.seq1) |=> !r.lowerIsSecond)
        else $error("tie or lower second sequence swapped banks");
    AST_SECOND_HIGHER: assert property (@(posedge clock) disable iff (rst)
        sSeq2Ok and (flashData[15:0] > r.seq1) |=> r.lowerIsSecond)
        else $error("higher second sequence did not swap");
    AST_BAD_COMPL_ALT: assert property (@(posedge clock) disable iff (rst)
        r.state == BCS_SEQ1 && flashAck && r.flashReq && !r.alt && !seqValid(flashData)
        |=> r.alt && r.flashReq && r.state == BCS_SEQ1)
        else $error("bad complement not retried");
    AST_ALT_ADDR: assert property (@(posedge clock) disable iff (rst)
        r.flashReq && r.alt |-> r.flashAddr[3])
        else $error("alternate fetch used primary address");
    AST_CFG_BANK: assert property (@(posedge clock) disable iff (rst)
        r.state == BCS_CFG && r.flashReq |-> r.flashBank == r.lowerIsSecond)
        else $error("config read from wrong bank");
    AST_ECC_ERR: assert property (@(posedge clock) disable iff (rst)
        r.flashReq && flashAck && flashEccUncorr && !r.alt |=> r.cfgErr ##0 r.alt)
        else $error("ecc error not flagged");
    AST_BOTH_FAIL: assert property (@(posedge clock) disable iff (rst)
        r.state == BCS_CFG && r.flashReq && flashAck && flashEccUncorr && r.alt
        |=> r.cfgFail)
        else $error("double failure not flagged");
    AST_HOLD: assert property (@(posedge clock) disable iff (rst)
        r.state == BCS_DONE |=> r.state == BCS_DONE && $stable(r.cfg)
            && $stable(r.lowerIsSecond))
        else $error("loaded state changed after done");
    AST_IRQ: assert property (@(posedge clock) disable iff (rst)
        irq == |(r.status & r.mask))
        else $error("irq mismatch");

    // Steps that the properties below are built from
    sequence sFlashTake;
        r.flashReq && flashAck;
    endsequence
    sequence sCfgGood;
        sFlashTake ##0 (r.state == BCS_CFG && !flashEccUncorr);
    endsequence
    sequence sSeqBadCompl;
        sFlashTake ##0 ((r.state == BCS_SEQ1 || r.state == BCS_SEQ2) && !flashEccUncorr
            && !seqValid(flashData));
    endsequence
    sequence sEnterDone;
        (r.state == BCS_CFG) ##1 (r.state == BCS_DONE);
    endsequence

    // Start-up opens with the first bank's primary sequence word
    AST_FIRST_REQ: assert property (@(posedge clock) disable iff (rst)
        r.state == BCS_IDLE |=> r.state == BCS_SEQ1 && r.flashReq && !r.flashBank
            && r.flashAddr == 5'h00)
        else $error("start-up did not request the first sequence word");
    // No configuration word is fetched while the mapping is open
    AST_SEQ_ONLY: assert property (@(posedge clock) disable iff (rst)
        r.flashReq && (r.state == BCS_SEQ1 || r.state == BCS_SEQ2)
        |-> r.flashAddr[2:0] == `BCS_IDX_SEQ)
        else $error("config word fetched before mapping was fixed");
    // Config reads walk the lower bank, primary before alternate
    AST_CFG_ADDR: assert property (@(posedge clock) disable iff (rst)
        r.state == BCS_CFG && r.flashReq
        |-> r.flashAddr[2:0] == r.idx && r.flashAddr[3] == r.alt)
        else $error("config fetch address does not match word and copy");
    // A bad complement alone is not an ECC event
    AST_COMPL_NO_ERR: assert property (@(posedge clock) disable iff (rst)
        sSeqBadCompl ##0 (!r.cfgErr) |=> !r.cfgErr)
        else $error("complement failure raised the error flag");
    // Signature word taken as read when its copy is clean
    AST_SIG_LOAD: assert property (@(posedge clock) disable iff (rst)
        sCfgGood ##0 (r.idx == `BCS_IDX_SIG && !r.cfgFail)
        |=> r.cfg[0] == $past(flashData))
        else $error("signature word not taken from the flash");
    // Double failure leaves only defaults behind
    AST_FAIL_DEFAULT: assert property (@(posedge clock) disable iff (rst)
        sEnterDone ##0 (r.cfgFail) |-> r.cfg[0] == `BCS_DEF_WORD
            && r.cfg[1] == `BCS_DEF_WORD && r.cfg[4] == `BCS_DEF_WORD)
        else $error("double failure did not apply the default configuration");
    // Completion posts done, error and fail as status events
    AST_DONE_EVENT: assert property (@(posedge clock) disable iff (rst)
        sEnterDone |-> r.status[`BCS_ST_DONE] && r.status[`BCS_ST_ERR] == r.cfgErr
            && r.status[`BCS_ST_FAIL] == r.cfgFail)
        else $error("completion did not post its status events");

    // Register bus timing: one wait state after the first access edge
    AST_APB_WAIT: assert property (@(posedge clock) disable iff (rst)
        psel && penable && !pready |=> pready)
        else $error("access phase not answered after one wait state");
    // Ready stands for exactly one cycle
    AST_APB_PULSE: assert property (@(posedge clock) disable iff (rst)
        pready |=> !pready)
        else $error("ready held past one cycle");
    // Mask changes at the ready edge and not before
    AST_MASK_WRITE: assert property (@(posedge clock) disable iff (rst)
        psel && penable && pwrite && pready && paddr == `BCS_OFF_MASK
        |=> r.mask == $past(wrMask))
        else $error("mask write did not land at the ready edge");
    // A wait-state edge must leave the mask alone
    AST_MASK_EARLY: assert property (@(posedge clock) disable iff (rst)
        psel && penable && pwrite && !pready |=> $stable(r.mask))
        else $error("mask changed before the ready edge");
endmodule

//--- rtl/bcs_map.svh
// Register offsets, field positions, default values and word indices of the boot config selector
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH
// APB register byte offsets
`define BCS_OFF_STATUS 12'h000
`define BCS_OFF_MASK 12'h004
`define BCS_OFF_RESET_CONTROL_REGISTER 12'h008
`define BCS_OFF_SIG 12'h00c
`define BCS_OFF_CP 12'h010
`define BCS_OFF_CFG0 12'h014
`define BCS_OFF_CFG1 12'h018
`define BCS_OFF_CFG2 12'h01c
`define BCS_OFF_MAP 12'h020
// Reset control register field positions
`define BCS_RESET_CONTROL_REGISTER_ERR_BIT 27
`define BCS_RESET_CONTROL_REGISTER_FAIL_BIT 26
// Status / mask bit positions
`define BCS_ST_DONE 0
`define BCS_ST_ERR 1
`define BCS_ST_FAIL 2
// Word indices inside a bank (primary; alternate adds ALT_OFS)
`define BCS_IDX_SEQ 3'h0
`define BCS_IDX_SIG 3'h1
`define BCS_IDX_CP 3'h2
`define BCS_IDX_CFG0 3'h3
`define BCS_ALT_OFS 4'h8
// Index of the last word loaded from the lower bank
`define BCS_NUM_WORDS 3'h5
// Default configuration values
`define BCS_DEF_WORD 32'hffff_ffff
`endif

//--- rtl/bcs_pkg.sv
// Types shared by the boot config selector
package bcs_pkg;
    typedef enum logic [2:0] {
        BCS_IDLE = 3'b000,
        BCS_SEQ1 = 3'b001,
        BCS_SEQ2 = 3'b010,
        BCS_CFG = 3'b011,
        BCS_DONE = 3'b100
    } bcs_state_t;
    typedef struct packed {
        bcs_state_t state;
        logic alt;
        logic [2:0] idx;
        logic rdPend;
        logic [15:0] seq1;
        logic [15:0] seq2;
        logic lowerIsSecond;
        logic [5:0][31:0] cfg;
        logic cfgErr;
        logic cfgFail;
        logic [2:0] status;
        logic [2:0] mask;
        logic irq;
        logic flashReq;
        logic [4:0] flashAddr;
        logic flashBank;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } bcs_regs_t;
endpackage

//--- verification/bcs_flash_model.sv
// Boot flash model: two banks of primary and alternate words with ECC marks
`timescale 1ns/1ps
module bcs_flash_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Read port
    input wire logic flashReq,
    input wire logic flashBank,
    input wire logic [4:0] flashAddr,
    output logic flashAck,
    output logic [31:0] flashData,
    output logic flashEccUncorr
);
    logic [31:0] mem [2][32];
    logic bad [2][32];
    logic [1:0] waitCnt;
    logic slow;
    // ----------------------------------------
    // One word per request, alternating prompt and slow replies
    // ----------------------------------------
    // Outside an answer the data bus flips each cycle, so a stale word never holds steady
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            flashAck <= 1'b0;
            flashData <= 32'h0;
            flashEccUncorr <= 1'b0;
            waitCnt <= 2'h0;
            slow <= 1'b0;
        end else if (flashReq && !flashAck && waitCnt == 2'h0) begin
            flashAck <= 1'b1;
            flashData <= mem[flashBank][flashAddr];
            flashEccUncorr <= bad[flashBank][flashAddr];
            slow <= ~slow;
            waitCnt <= slow ? 2'h0 : 2'h2;
        end else begin
            flashAck <= 1'b0;
            flashData <= ~flashData;
            flashEccUncorr <= ~flashEccUncorr;
            if (flashReq && !flashAck)
                waitCnt <= waitCnt - 2'h1;
        end
    end
endmodule

//--- verification/test_boot_config_selector.sv
// Testbench for the boot config selector: alias choice, fallback and APB status
`timescale 1ns/1ps
`include "bcs_map.svh"
module test_boot_config_selector;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, irq, loadDone, lowerIsSecond;
    logic flashReq, flashBank, flashAck, flashEccUncorr, errFlag, failFlag, e;
    logic [4:0] flashAddr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, flashData, sigWord, cpWord, q;
    logic [95:0] cfgWords;
    int n_errors, checks;
    // ----------------------------------------
    // Design and flash partner
    // ----------------------------------------
    bcs_boot_config_selector dut_u (.clock(clock), .rst(rst), .flashReq(flashReq),
        .flashBank(flashBank), .flashAddr(flashAddr), .flashAck(flashAck),
        .flashData(flashData), .flashEccUncorr(flashEccUncorr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .deviceSignatureWord(sigWord),
        .codeProtectWord(cpWord), .deviceConfigWords(cfgWords), .lowerIsSecond(lowerIsSecond),
        .bootCfgErrorFlag(errFlag), .bootCfgFailFlag(failFlag), .loadDone(loadDone), .irq(irq));
    bcs_flash_model mem_u (.clock(clock), .rst(rst), .flashReq(flashReq),
        .flashBank(flashBank), .flashAddr(flashAddr), .flashAck(flashAck),
        .flashData(flashData), .flashEccUncorr(flashEccUncorr));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task chk(input logic [95:0] got, input logic [95:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Setup, access, then hold until pready is seen at a rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // No fixed wait: only the watchdog ends a hung transfer
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Whole rows of known words; the sequence word carries its complement above it
    task fill(input logic [15:0] s0, input logic [15:0] s1);
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 32; i++) begin
                mem_u.mem[b][i] = 32'hc000_0000 | (b << 12) | i;
                mem_u.bad[b][i] = 1'b0;
            end
        end
        mem_u.mem[0][0] = {~s0, s0};
        mem_u.mem[1][0] = {~s1, s1};
    endtask
    task boot;
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        while (loadDone !== 1'b1) begin
            @(posedge clock);
        end
    endtask
    // Outputs expected from the lower bank, or defaults on a double failure
    task expect_load(input logic lb, input int si, input logic er, input logic fl);
        logic [31:0] d;
        d = `BCS_DEF_WORD;
        chk(lowerIsSecond, lb);
        chk(errFlag, er);
        chk(failFlag, fl);
        chk(sigWord, fl ? d : mem_u.mem[lb][si]);
        chk(cpWord, fl ? d : mem_u.mem[lb][2]);
        chk(cfgWords, fl ? {d, d, d} : {mem_u.mem[lb][5], mem_u.mem[lb][4], mem_u.mem[lb][3]});
    endtask
    task end_sim;
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #(25ns * 8000);
        n_errors++;
        end_sim;
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        fill(16'h0007, 16'h0007);
        boot;
        expect_load(1'b0, 1, 1'b0, 1'b0);
        apb(1'b0, `BCS_OFF_MASK, 32'h0);
        chk(q, 32'h0);
        chk(irq, 1'b0);
        apb(1'b1, `BCS_OFF_MASK, 32'h1);
        repeat (3) @(posedge clock);
        chk(irq, 1'b1);
        apb(1'b0, `BCS_OFF_STATUS, 32'h0);
        chk(q, 32'h1);
        repeat (3) @(posedge clock);
        chk(irq, 1'b0);
        apb(1'b0, `BCS_OFF_STATUS, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        chk(e, 1'b1);
        apb(1'b1, `BCS_OFF_SIG, 32'h5);
        chk(e, 1'b1);
        chk(flashReq, 1'b0);
        expect_load(1'b0, 1, 1'b0, 1'b0);
        fill(16'h7fff, 16'h8000);
        boot;
        expect_load(1'b1, 1, 1'b0, 1'b0);
        apb(1'b0, `BCS_OFF_MAP, 32'h0);
        chk(q, 32'h3);
        fill(16'h0009, 16'h0005);
        mem_u.mem[0][0] = 32'h1234_0009;
        mem_u.mem[0][8] = {~16'h0002, 16'h0002};
        boot;
        expect_load(1'b1, 1, 1'b0, 1'b0);
        fill(16'h0004, 16'h0003);
        mem_u.bad[0][1] = 1'b1;
        boot;
        expect_load(1'b0, 9, 1'b1, 1'b0);
        fill(16'h0004, 16'h0003);
        mem_u.bad[0][4] = 1'b1;
        mem_u.bad[0][12] = 1'b1;
        boot;
        expect_load(1'b0, 1, 1'b1, 1'b1);
        apb(1'b0, `BCS_OFF_RESET_CONTROL_REGISTER, 32'h0);
        chk(q, 32'h0c00_0000);
        apb(1'b0, `BCS_OFF_STATUS, 32'h0);
        chk(q, 32'h7);
        end_sim;
    end
endmodule
